// ### design/fscsc_pkg.sv
// Package of constants and types for the fan smoothing and core sleep configuration block.
package fscsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  localparam logic [7:0] MASK_ADDR = 8'h24;
  localparam logic [7:0] STATE_ADDR = 8'h28;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'hC7;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_SLOW_LSB = 0;
  localparam int CFG_SLEEP_GATE = 6;
  localparam int CFG_EXTRA = 7;
  localparam int EVT_LOW_ENTER = 0;
  localparam int EVT_LOW_EXIT = 1;

  // ----------------------------------------------------------------
  // Smoothing arithmetic and responses
  // ----------------------------------------------------------------
  localparam int NUM_CH = 3;
  localparam int BASE_W = 12;
  localparam int EFF_W = 16;
  localparam int SLOW_SHIFT = 2;
  // 713/512 = 1.3926, the closest ninth-power-of-two ratio to 1.392.
  localparam logic [9:0] EXTRA_MUL = 10'h2C9;
  localparam int EXTRA_SHIFT = 9;
  localparam int SYNC_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } fscsc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fscsc_axil_rsp_t;

  function automatic logic fscsc_mapped(input logic [ADDR_W-1:0] a);
    return (a == CFG_ADDR) || (a == STATUS_ADDR) || (a == MASK_ADDR) || (a == STATE_ADDR);
  endfunction

endpackage

// ### design/fscsc_sync2.sv
// Two-stage synchroniser for the pin inputs of the block.
`timescale 1ns/1ps
`default_nettype none
module fscsc_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fscsc_pkg::SYNC_W-1:0] pin_in,
  output logic [fscsc_pkg::SYNC_W-1:0] pin_sync
);

  typedef struct packed {
    logic [fscsc_pkg::SYNC_W-1:0] meta;
    logic [fscsc_pkg::SYNC_W-1:0] stable;
  } fscsc_sync_state_t;

  fscsc_sync_state_t s_q;
  fscsc_sync_state_t s_d;

  always_comb begin
    s_d.meta = pin_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.stable;

endmodule
`default_nettype wire

// ### design/fscsc_smooth_scale.sv
// Scales one channel's programmed smoothing time by the stretch options.
`timescale 1ns/1ps
`default_nettype none
module fscsc_smooth_scale (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fscsc_pkg::BASE_W-1:0] base_time,
  input wire logic slow,
  input wire logic extra,
  output logic [fscsc_pkg::EFF_W-1:0] eff_time
);

  typedef struct packed {
    logic [fscsc_pkg::EFF_W-1:0] eff;
  } fscsc_scale_state_t;

  fscsc_scale_state_t s_q;
  fscsc_scale_state_t s_d;
  logic [13:0] stretched;
  logic [23:0] product;
  localparam int EFF_W = fscsc_pkg::EFF_W;

  always_comb begin
    stretched = slow ? {base_time, 2'b00} : {2'b00, base_time};
    product = 24'(stretched) * 24'(fscsc_pkg::EXTRA_MUL);
    s_d.eff = extra ? EFF_W'(product >> fscsc_pkg::EXTRA_SHIFT) : {2'b00, stretched};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign eff_time = s_q.eff;

  a_slow_times_four: assert property (@(posedge aclk) disable iff (!aresetn)
    (slow && !extra) |=> eff_time == {2'b00, $past(base_time), 2'b00})
    else $error("Stretched smoothing time is not four times the base.");
  a_plain_passes: assert property (@(posedge aclk) disable iff (!aresetn)
    (!slow && !extra) |=> eff_time == {4'h0, $past(base_time)})
    else $error("Unstretched smoothing time differs from the base.");
  a_both_combine: assert property (@(posedge aclk) disable iff (!aresetn)
    (slow && extra && base_time == 12'h100) |=> eff_time == 16'h0592)
    else $error("Combined stretch does not apply both factors.");

endmodule
`default_nettype wire

// ### design/fscsc_top.sv
// Configuration register for fan smoothing and core-voltage sleep gating, with AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none
module fscsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fscsc_pkg::fscsc_axil_req_t s_axil_req,
  output fscsc_pkg::fscsc_axil_rsp_t s_axil_rsp,
  input wire logic config_lock,
  input wire logic [7:0] core_voltage_input,
  input wire logic [7:0] core_voltage_low_limit,
  input wire logic standby_supply_pin,
  input wire logic processor_hot_input,
  input wire logic alert_enable,
  input wire logic spin_up_done,
  input wire logic [fscsc_pkg::NUM_CH-1:0][fscsc_pkg::BASE_W-1:0] smooth_base_time,
  output logic [fscsc_pkg::NUM_CH-1:0][fscsc_pkg::EFF_W-1:0] smooth_eff_time,
  output logic core_low_status,
  output logic bus_alert,
  output logic processor_hot_monitor_en,
  output logic processor_hot_seen,
  output logic spin_up_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fscsc_pkg::fscsc_axil_rsp_t rsp;
    logic aw_have;
    logic [fscsc_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] cfg;
    logic [1:0] status;
    logic [1:0] mask;
    logic core_low;
    logic alert;
    logic hot_en;
    logic hot_seen;
    logic spin_up;
    logic irq;
  } fscsc_state_t;

  fscsc_state_t q;
  fscsc_state_t n;
  logic [fscsc_pkg::SYNC_W-1:0] pins_sync;
  logic standby_sync;
  logic hot_sync;
  logic condition;
  logic [1:0] evt_set;
  logic [1:0] evt_clr;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fscsc_sync2 u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({processor_hot_input, standby_supply_pin}),
    .pin_sync(pins_sync)
  );

  assign standby_sync = pins_sync[0];
  assign hot_sync = pins_sync[1];

  // ----------------------------------------------------------------
  // Smoothing scalers, one per temperature channel
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < fscsc_pkg::NUM_CH; ch++) begin : g_ch
      fscsc_smooth_scale u_scale (
        .aclk(aclk),
        .aresetn(aresetn),
        .base_time(smooth_base_time[ch]),
        .slow(q.cfg[fscsc_pkg::CFG_SLOW_LSB + ch]),
        .extra(q.cfg[fscsc_pkg::CFG_EXTRA]),
        .eff_time(smooth_eff_time[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    evt_clr = 2'h0;
    rd_word = 32'h0000_0000;

    // Gating is only armed on standby power; on main power the low reading is a real fault elsewhere.
    condition = q.cfg[fscsc_pkg::CFG_SLEEP_GATE] && standby_sync
                && (core_voltage_input < core_voltage_low_limit);
    evt_set = 2'h0;
    evt_set[fscsc_pkg::EVT_LOW_ENTER] = condition && !q.core_low;
    evt_set[fscsc_pkg::EVT_LOW_EXIT] = q.core_low && !condition;

    n.core_low = condition;
    n.alert = condition && alert_enable;
    n.hot_en = !condition;
    n.hot_seen = hot_sync && !condition;
    if (q.spin_up && spin_up_done) begin
      n.spin_up = 1'b0;
    end
    if (q.core_low && !condition) begin
      n.spin_up = 1'b1;
    end

    // Write path: address and data may arrive in either order.
    if (q.rsp.bvalid && s_axil_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s_axil_req.awvalid && q.rsp.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axil_req.awaddr;
    end
    if (s_axil_req.wvalid && q.rsp.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axil_req.wdata;
      n.w_strb = s_axil_req.wstrb;
    end
    if (n.aw_have && n.w_have && !n.rsp.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = fscsc_pkg::fscsc_mapped(n.aw_addr) ? fscsc_pkg::RESP_OKAY : fscsc_pkg::RESP_DECERR;
      if (n.w_strb[0]) begin
        if (n.aw_addr == fscsc_pkg::CFG_ADDR && !config_lock) begin
          n.cfg = n.w_data[7:0] & fscsc_pkg::CFG_WMASK;
        end
        if (n.aw_addr == fscsc_pkg::MASK_ADDR) begin
          n.mask = n.w_data[1:0];
        end
      end
    end
    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready = !n.w_have && !n.rsp.bvalid;

    // Read path: one-cycle answer, status clears on the read.
    if (q.rsp.rvalid && s_axil_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (s_axil_req.arvalid && q.rsp.arready) begin
      unique case (s_axil_req.araddr)
        fscsc_pkg::CFG_ADDR: begin
          rd_word[7:0] = q.cfg;
        end
        fscsc_pkg::STATUS_ADDR: begin
          rd_word[1:0] = q.status;
          evt_clr = 2'h3;
        end
        fscsc_pkg::MASK_ADDR: begin
          rd_word[1:0] = q.mask;
        end
        fscsc_pkg::STATE_ADDR: begin
          rd_word[4:0] = {config_lock, q.spin_up, q.alert, !q.hot_en, q.core_low};
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = rd_word;
      n.rsp.rresp = fscsc_pkg::fscsc_mapped(s_axil_req.araddr) ? fscsc_pkg::RESP_OKAY : fscsc_pkg::RESP_DECERR;
    end
    n.rsp.arready = !n.rsp.rvalid;

    // A fresh event beats the read that clears it, so nothing is lost.
    n.status = (q.status & ~evt_clr) | evt_set;
    n.irq = |(n.status & n.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cfg <= fscsc_pkg::CFG_RESET;
      q.status <= fscsc_pkg::EVT_RESET;
      q.mask <= fscsc_pkg::EVT_RESET;
      q.hot_en <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axil_rsp = q.rsp;
  assign core_low_status = q.core_low;
  assign bus_alert = q.alert;
  assign processor_hot_monitor_en = q.hot_en;
  assign processor_hot_seen = q.hot_seen;
  assign spin_up_req = q.spin_up;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_clears_cfg: assert property (@(posedge aclk)
    !aresetn |=> q.cfg == 8'h00)
    else $error("Config register is not zero after reset.");

  a_lock_freezes_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    config_lock |=> q.cfg == $past(q.cfg))
    else $error("Config register changed while locked.");

  a_low_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.cfg[6] && standby_sync && core_voltage_input < core_voltage_low_limit) |=> core_low_status)
    else $error("Core-voltage-low flag not set.");

  a_low_needs_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.cfg[6] |=> !core_low_status)
    else $error("Core-voltage-low flag set with gating off.");

  a_alert_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_alert |-> core_low_status && $past(alert_enable))
    else $error("Bus alert raised without enabled low condition.");

  a_hot_suspended: assert property (@(posedge aclk) disable iff (!aresetn)
    core_low_status |-> !processor_hot_monitor_en && !processor_hot_seen)
    else $error("Processor-hot monitoring active during low condition.");

  a_spin_on_recover: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(core_low_status) |-> spin_up_req && processor_hot_monitor_en)
    else $error("Recovery did not resume monitoring and start spin-up.");

  a_spin_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (spin_up_req && !spin_up_done) |=> spin_up_req)
    else $error("Spin-up request dropped before completion.");

  a_enter_event: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(core_low_status) |-> q.status[0] ##1 q.status[0] || $past(s_axil_req.arvalid))
    else $error("Entry event not recorded in status.");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axil_req.awvalid && s_axil_rsp.awready && s_axil_req.wvalid && s_axil_rsp.wready) |=> s_axil_rsp.bvalid)
    else $error("Write response missing after address and data.");

  a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axil_rsp.bvalid && !s_axil_req.bready) |=> s_axil_rsp.bvalid && $stable(s_axil_rsp.bresp))
    else $error("Write response dropped before it was taken.");

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axil_req.arvalid && s_axil_rsp.arready) |=> s_axil_rsp.rvalid)
    else $error("Read data missing after address.");

  a_rdata_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axil_rsp.rvalid && !s_axil_req.rready) |=> s_axil_rsp.rvalid && $stable(s_axil_rsp.rdata))
    else $error("Read data changed before it was taken.");

  a_cfg_only_written: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(q.cfg) |-> $rose(s_axil_rsp.bvalid) && !$past(config_lock))
    else $error("Config register changed outside an unlocked write.");

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    q.cfg[5:3] == 3'h0)
    else $error("Reserved config bits are not zero.");

  a_gate_off_standby: assert property (@(posedge aclk) disable iff (!aresetn)
    !standby_sync |=> !core_low_status)
    else $error("Core-voltage-low flag set on main power.");

  a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.status[0] && !(s_axil_req.arvalid && s_axil_req.araddr == fscsc_pkg::STATUS_ADDR)) |=> q.status[0])
    else $error("Entry event lost without a status read.");

  a_alert_when_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (condition && alert_enable) |=> bus_alert)
    else $error("Bus alert missing for enabled low condition.");

  a_alert_off_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    !alert_enable |=> !bus_alert)
    else $error("Bus alert raised while disabled.");

  a_low_needs_below: assert property (@(posedge aclk) disable iff (!aresetn)
    (core_voltage_input >= core_voltage_low_limit) |=> !core_low_status)
    else $error("Core-voltage-low flag held above the limit.");

  a_hot_resumes: assert property (@(posedge aclk) disable iff (!aresetn)
    !core_low_status |-> processor_hot_monitor_en)
    else $error("Processor-hot monitoring not resumed.");

  a_hot_follows_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (hot_sync && !condition) |=> processor_hot_seen)
    else $error("Processor-hot input not seen while monitoring.");

  a_spin_needs_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(spin_up_req) |-> $past(core_low_status))
    else $error("Spin-up started without a recovery.");

  a_spin_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    (spin_up_req && spin_up_done && !core_low_status) |=> !spin_up_req)
    else $error("Spin-up request held after completion.");

  a_exit_event: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(core_low_status) |-> q.status[1])
    else $error("Exit event not recorded in status.");

endmodule
`default_nettype wire

// ### verif/tb_fscsc_top.sv
// Self-checking testbench for the fan smoothing and core sleep configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_fscsc_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  fscsc_pkg::fscsc_axil_req_t req = '0;
  fscsc_pkg::fscsc_axil_rsp_t rsp;
  logic config_lock = 1'b0;
  logic [7:0] volt = 8'h80;
  logic [7:0] limit = 8'h40;
  logic standby = 1'b0;
  logic hot = 1'b0;
  logic alert_en = 1'b0;
  logic spin_done = 1'b0;
  logic [2:0][11:0] base = '0;
  logic [2:0][15:0] eff;
  logic low_st, alert, mon_en, hot_seen, spin_req, irq;
  logic [1:0] r;
  logic [31:0] d;
  logic [7:0] cfg;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  fscsc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axil_req(req), .s_axil_rsp(rsp), .config_lock(config_lock),
    .core_voltage_input(volt), .core_voltage_low_limit(limit), .standby_supply_pin(standby),
    .processor_hot_input(hot), .alert_enable(alert_en), .spin_up_done(spin_done), .smooth_base_time(base),
    .smooth_eff_time(eff), .core_low_status(low_st), .bus_alert(alert), .processor_hot_monitor_en(mon_en),
    .processor_hot_seen(hot_seen), .spin_up_req(spin_req), .irq(irq));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Reference scaling; the extra factor is the package's closest ninth-power-of-two ratio for 39.2 percent.
  function automatic logic [15:0] exp_eff(input logic [11:0] b, input logic s, input logic x);
    logic [31:0] e;
    e = {20'h0, b} * (s ? 32'h4 : 32'h1);
    if (x) e = (e * {22'h0, fscsc_pkg::EXTRA_MUL}) >> fscsc_pkg::EXTRA_SHIFT;
    return e[15:0];
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR t=%0t timeout", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(99));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wait_edges(3);
    axr(fscsc_pkg::CFG_ADDR, d, r);
    chk_val(d, 32'h0, "cfg reset");
    axr(fscsc_pkg::MASK_ADDR, d, r);
    chk_val(d, 32'h0, "mask reset");
    chk_val({30'h0, mon_en, irq}, 32'h2, "idle outputs");
    $display("test reset done");

    // Writable bits, unmapped address, and smoothing scaling per channel.
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      cfg = (i == 0) ? 8'h87 : 8'($urandom());
      base <= (i == 0) ? {3{12'hFFF}} : {12'($urandom()), 12'($urandom()), 12'($urandom())};
      axw(fscsc_pkg::CFG_ADDR, {24'($urandom()), cfg}, r);
      chk_val(r, fscsc_pkg::RESP_OKAY, "cfg bresp");
      axr(fscsc_pkg::CFG_ADDR, d, r);
      chk_val(d, {24'h0, cfg & 8'hC7}, "cfg readback");
      wait_edges(2);
      for (int c = 0; c < 3; c++) begin
        chk_val(eff[c], exp_eff(base[c], cfg[c], cfg[7]), "eff time");
      end
    end
    axw(8'h44, 32'hFFFF_FFFF, r);
    chk_val(r, fscsc_pkg::RESP_DECERR, "unmapped bresp");
    axr(8'h44, d, r);
    chk_val(d, 32'h0, "unmapped rdata");
    chk_val({30'h0, r}, {30'h0, fscsc_pkg::RESP_DECERR}, "unmapped rresp");
    $display("test scaling done");

    // Lock freezes the register while the write still completes normally.
    config_lock <= 1'b1;
    axw(fscsc_pkg::CFG_ADDR, {24'h0, ~cfg}, r);
    chk_val(r, fscsc_pkg::RESP_OKAY, "locked bresp");
    axr(fscsc_pkg::CFG_ADDR, d, r);
    chk_val(d, {24'h0, cfg & 8'hC7}, "locked cfg");
    config_lock <= 1'b0;
    $display("test lock done");

    // A reset in mid-run must clear a written register again.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_edges(3);
    axr(fscsc_pkg::CFG_ADDR, d, r);
    chk_val(d, 32'h0, "cfg after reset");
    $display("test mid reset done");

    // Core-low gating: no effect off standby, then entry and recovery on standby.
    axw(fscsc_pkg::MASK_ADDR, 32'h3, r);
    axw(fscsc_pkg::CFG_ADDR, 32'h40, r);
    alert_en <= 1'($urandom());
    hot <= 1'b1;
    volt <= 8'h10;
    limit <= 8'h11;
    wait_edges(4);
    chk_val({31'h0, low_st}, 32'h0, "no standby");
    @(posedge aclk);
    standby <= 1'b1;
    wait_edges(4);
    chk_val({31'h0, low_st}, 32'h1, "core low");
    chk_val({31'h0, alert}, {31'h0, alert_en}, "alert");
    chk_val({30'h0, mon_en, hot_seen}, 32'h0, "hot suspended");
    chk_val({31'h0, irq}, 32'h1, "irq raised");
    axr(fscsc_pkg::STATE_ADDR, d, r);
    chk_val(d, {27'h0, 2'b00, alert_en, 2'b11}, "state low");
    @(posedge aclk);
    volt <= 8'h12;
    wait_edges(3);
    chk_val({29'h0, low_st, mon_en, spin_req}, 32'h3, "recovery");
    chk_val({31'h0, hot_seen}, 32'h1, "hot resumed");
    @(posedge aclk);
    spin_done <= 1'b1;
    @(posedge aclk);
    spin_done <= 1'b0;
    wait_edges(2);
    chk_val({31'h0, spin_req}, 32'h0, "spin ended");
    axr(fscsc_pkg::STATUS_ADDR, d, r);
    chk_val(d, 32'h3, "status events");
    axr(fscsc_pkg::STATUS_ADDR, d, r);
    chk_val(d, 32'h0, "status cleared");
    wait_edges(1);
    chk_val({31'h0, irq}, 32'h0, "irq cleared");
    $display("test core low done");
    wrap_up();
  end
endmodule
`default_nettype wire
